// File: charge_time_edge_control_test.sv
// Testbench: registers, edge status and delay pulse of the charge-time unit
`timescale 1ns/1ps
`default_nettype none
`include "charge_time_unit_regs.vh"
`define CMP(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); end end
module charge_time_edge_control_test;
    logic        clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, cpu_idle = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, src_level = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, current_range;
    logic [5:0]  current_trim;
    logic        source_to_comparator_b, current_ground, current_source_on, charge_delay_capacitor;
    logic        delay_pulse_out, trigger_out, comparator_trip;
    logic        edge_pin_one, edge_pin_two, output_compare_source, timer_source;
    logic [15:0] ctl;
    logic [1:0]  bresp_seen;
    logic [15:0] cur_vals [4] = '{16'h7DFF, 16'h8600, 16'h0300, 16'hFC00};
    int          error_cnt = 0, tests_run = 0, cycles = 0;

    charge_time_unit DUT (.*);
    // Long enough charge time to read the status word while charging
    edge_comparator_model #(.TRIP_CYCLES(12)) partner (.*);

    always #5 clock = ~clock;
    // Whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Trailing cycles let the registered outputs follow the new value
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        bresp_seen = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] mask, exp, input logic [1:0] resp);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        `CMP(s_axi_rdata & mask, exp, "read data")
        `CMP(s_axi_rresp, resp, "read response")
    endtask

    task automatic set_src(input logic [3:0] v);
        @(posedge clock);
        src_level <= v;
        repeat (3) @(posedge clock);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(`CTU_ADDR_CONTROL, 32'hFFFFFFFF, 32'h0, 2'h0);
        rd_chk(`CTU_ADDR_CURRENT, 32'hFFFFFFFF, 32'h0, 2'h0);
        rd_chk(4'hC, 32'hFFFFFFFF, 32'h0, 2'h2);
        wr(`CTU_ADDR_LINK, 16'hFFFF);
        `CMP(bresp_seen, 2'h2, "status write refused")
        rd_chk(`CTU_ADDR_CONTROL, 32'hFFFFFFFF, 32'h0, 2'h0);
        wr(`CTU_ADDR_CONTROL, 16'hFFFC);
        `CMP(bresp_seen, 2'h0, "write response")
        rd_chk(`CTU_ADDR_CONTROL, 32'hFFFFFFFF, 32'h0000BFFC, 2'h0);
        `CMP({trigger_out, current_ground, source_to_comparator_b}, 3'b111, "enabled outputs")
        cpu_idle <= 1'b1;
        repeat (3) @(posedge clock);
        `CMP({trigger_out, current_ground, source_to_comparator_b}, 3'b010, "idle stop")
        wr(`CTU_ADDR_CONTROL, 16'hDFFC);
        `CMP({trigger_out, current_ground, source_to_comparator_b}, 3'b111, "idle run")
        wr(`CTU_ADDR_CONTROL, 16'h5FFC);
        `CMP({trigger_out, current_ground, source_to_comparator_b}, 3'b010, "disabled")
        cpu_idle <= 1'b0;
        wr(`CTU_ADDR_CONTROL, 16'h8000);
        foreach (cur_vals[i]) begin
            wr(`CTU_ADDR_CURRENT, cur_vals[i]);
            rd_chk(`CTU_ADDR_CURRENT, 32'hFFFFFFFF, {16'h0000, cur_vals[i] & 16'hFF00}, 2'h0);
            `CMP({current_trim, current_range, current_source_on},
                {cur_vals[i][15:8], cur_vals[i][9:8] != 2'h0}, "current outputs")
        end
        // Channel 1 rising, channel 2 falling; wrong source or edge first
        for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 4; s++) begin
                ctl = 16'h8800 | (16'(s) << (ch ? 5 : 2)) | (ch ? 16'h0000 : 16'h0010);
                wr(`CTU_ADDR_CONTROL, ctl);
                set_src(ch ? 4'(1 << s) : 4'(1 << (s ^ 1)));
                rd_chk(`CTU_ADDR_CONTROL, ch + 1, 32'h0, 2'h0);
                set_src(ch ? 4'h0 : 4'(1 << s));
                rd_chk(`CTU_ADDR_CONTROL, ch + 1, ch + 1, 2'h0);
                set_src(4'h0);
                wr(`CTU_ADDR_CONTROL, ctl);
                rd_chk(`CTU_ADDR_CONTROL, ch + 1, 32'h0, 2'h0);
            end
        end
        wr(`CTU_ADDR_CONTROL, 16'h801C);
        set_src(4'h8);
        rd_chk(`CTU_ADDR_CONTROL, 32'h3, 32'h0, 2'h0);
        set_src(4'h0);
        wr(`CTU_ADDR_CONTROL, 16'h8CDC);
        set_src(4'h4);
        rd_chk(`CTU_ADDR_CONTROL, 32'h3, 32'h0, 2'h0);
        set_src(4'h8);
        set_src(4'hC);
        rd_chk(`CTU_ADDR_CONTROL, 32'h3, 32'h3, 2'h0);
        set_src(4'h0);
        wr(`CTU_ADDR_CONTROL, 16'h981C);
        @(posedge clock);
        src_level <= 4'h8;
        for (int n = 0; n < 10 && !charge_delay_capacitor; n++) @(posedge clock);
        `CMP(charge_delay_capacitor, 1'b1, "charging")
        rd_chk(`CTU_ADDR_LINK, 32'h1F, 32'h5, 2'h0);
        for (int n = 0; n < 20 && !delay_pulse_out; n++) @(posedge clock);
        `CMP(delay_pulse_out, 1'b1, "delay pulse")
        @(posedge clock);
        `CMP({delay_pulse_out, charge_delay_capacitor}, 2'b00, "pulse ended")
        // Clock enable low: an edge that comes and goes meanwhile is never seen
        set_src(4'h0);
        wr(`CTU_ADDR_CONTROL, 16'h881C);
        clk_en <= 1'b0;
        set_src(4'h8);
        set_src(4'h0);
        clk_en <= 1'b1;
        rd_chk(`CTU_ADDR_CONTROL, 32'h3, 32'h0, 2'h0);
        set_src(4'h8);
        rd_chk(`CTU_ADDR_CONTROL, 32'h3, 32'h1, 2'h0);
        report_and_stop();
    end
endmodule // charge_time_edge_control_test

bind charge_time_unit charge_time_unit_asserts u_asserts (.*);
`default_nettype wire

// File: charge_time_unit.v
// Charge-time unit: edge control, delay generation and AXI4-Lite register slave
//
// Summary of operation
// - Delay-gen bit 12 routes current source to comparator B input.
// - In delay-gen mode, charging starts on a qualified edge.
// - Pulse on delay output when comparator says capacitor passed reference.
// - Bit 15 enables the unit; cleared stops comparator routing, trigger, source enable and edges, not ground, range or trim.
// - Bit 13 set stops operation in idle; cleared keeps running.
// - Bit 11 cleared blocks all edges; set passes them.
// - Bit 10 set: edge 2 accepted only after edge 1.
// - Bit 9 set grounds the current source output.
// - Trigger output enabled only while bit 8 is set.
// - Polarity bit set selects rising edge, cleared falling; bits 7 and 4.
// - Source fields 6-5 and 3-2: pin one, pin two, compare, timer.
// - Status bit 1 set when an edge 2 event occurred.
// - Status bit 0 set when an edge 1 event occurred.
// - Six-bit two's complement current trim in current register bits 15-10.
// - Range bits 9-8: x100, x10, base, source disabled.
// - Unimplemented bits read zero and ignore writes.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "charge_time_unit_regs.vh"

module charge_time_unit (
    input  wire        clock,
    input  wire        arst_n,
    input  wire        clk_en,
    input  wire        cpu_idle,
    input  wire        edge_pin_one,
    input  wire        edge_pin_two,
    input  wire        output_compare_source,
    input  wire        timer_source,
    input  wire        comparator_trip,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         source_to_comparator_b,
    output reg         current_ground,
    output reg         current_source_on,
    output reg  [1:0]  current_range,
    output reg  [5:0]  current_trim,
    output reg         charge_delay_capacitor,
    output reg         delay_pulse_out,
    output reg         trigger_out
);

    localparam ST_IDLE     = 2'h0;
    localparam ST_CHARGING = 2'h1;
    localparam ST_PULSE    = 2'h2;

    reg        rst_sync1_reg;
    reg        rst_sync2_reg;
    wire       rst_n = rst_sync2_reg;

    reg [15:0] control_reg;
    reg [15:0] current_reg;
    reg [1:0]  state_reg;
    reg [3:0]  pulse_cnt_reg;
    reg [3:0]  sources_prev_reg;
    reg        aw_got_reg;
    reg        w_got_reg;
    reg [3:0]  aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    // Pick one of four sources by the 2-bit select field
    function src_pick;
        input [1:0] sel;
        input [3:0] srcs;
        begin
            case (sel)
                `CTU_SRC_PIN_ONE: src_pick = srcs[3];
                `CTU_SRC_PIN_TWO: src_pick = srcs[2];
                `CTU_SRC_COMPARE: src_pick = srcs[1];
                default:          src_pick = srcs[0];
            endcase
        end
    endfunction

    // Byte-lane merge of a 16-bit register, restricted to implemented bits
    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] data;
        input [1:0]  strb;
        input [15:0] wmask;
        reg   [15:0] m;
        begin
            m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
            lane_merge = (old & ~m) | (data & m);
        end
    endfunction

    wire [3:0] sources_now = {edge_pin_one, edge_pin_two, output_compare_source, timer_source};
    wire       unit_enable_bit  = control_reg[`CTU_BIT_ENABLE];
    wire       idle_stop_bit    = control_reg[`CTU_BIT_IDLE_STOP];
    wire       delay_gen_enable = control_reg[`CTU_BIT_DELAY_GEN];
    wire       edge_pass_bit    = control_reg[`CTU_BIT_EDGE_PASS];
    wire       edge_order_bit   = control_reg[`CTU_BIT_EDGE_ORDER];

    wire running = unit_enable_bit & ~(idle_stop_bit & cpu_idle);
    wire [1:0] sel1 = control_reg[`CTU_SEL1_HI:`CTU_SEL1_LO];
    wire [1:0] sel2 = control_reg[`CTU_SEL2_HI:`CTU_SEL2_LO];
    wire cur1  = src_pick(sel1, sources_now);
    wire prev1 = src_pick(sel1, sources_prev_reg);
    wire cur2  = src_pick(sel2, sources_now);
    wire prev2 = src_pick(sel2, sources_prev_reg);
    wire pol1  = control_reg[`CTU_BIT_POL1];
    wire pol2  = control_reg[`CTU_BIT_POL2];
    wire edge1_raw = pol1 ? (cur1 & ~prev1) : (~cur1 & prev1);
    wire edge2_raw = pol2 ? (cur2 & ~prev2) : (~cur2 & prev2);
    wire edge1_ev  = running & edge_pass_bit & edge1_raw;
    wire edge2_ev  = running & edge_pass_bit & edge2_raw &
                     (~edge_order_bit | control_reg[`CTU_BIT_SEEN1]);

    wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire wr_ctl  = wr_fire & (aw_addr_reg == `CTU_ADDR_CONTROL);
    wire wr_cur  = wr_fire & (aw_addr_reg == `CTU_ADDR_CURRENT);

    reg  [15:0] control_next;
    reg  [15:0] current_next;

    always @* begin
        control_next = control_reg;
        current_next = current_reg;
        if (wr_ctl) begin
            control_next = lane_merge(control_reg, w_data_reg[15:0], w_strb_reg[1:0], `CTU_CONTROL_WMASK);
        end
        if (wr_cur) begin
            current_next = lane_merge(current_reg, w_data_reg[15:0], w_strb_reg[1:0], `CTU_CURRENT_WMASK);
        end
        // Hardware set wins over a software clear in the same cycle
        if (edge1_ev) begin
            control_next[`CTU_BIT_SEEN1] = 1'b1;
        end
        if (edge2_ev) begin
            control_next[`CTU_BIT_SEEN2] = 1'b1;
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control_reg      <= `CTU_CONTROL_RESET;
            current_reg      <= `CTU_CURRENT_RESET;
            sources_prev_reg <= 4'h0;
            state_reg        <= ST_IDLE;
            pulse_cnt_reg    <= 4'h0;
            aw_got_reg       <= 1'b0;
            w_got_reg        <= 1'b0;
            aw_addr_reg      <= 4'h0;
            w_data_reg       <= 32'h00000000;
            w_strb_reg       <= 4'h0;
            s_axi_awready    <= 1'b0;
            s_axi_wready     <= 1'b0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= 2'h0;
            s_axi_arready    <= 1'b0;
            s_axi_rvalid     <= 1'b0;
            s_axi_rresp      <= 2'h0;
            s_axi_rdata      <= 32'h00000000;
            source_to_comparator_b <= 1'b0;
            current_ground         <= 1'b0;
            current_source_on      <= 1'b0;
            current_range          <= 2'h0;
            current_trim           <= 6'h00;
            charge_delay_capacitor <= 1'b0;
            delay_pulse_out        <= 1'b0;
            trigger_out            <= 1'b0;
        end else if (clk_en) begin
            control_reg      <= control_next;
            current_reg      <= current_next;
            sources_prev_reg <= sources_now;

            // Write channel: address and data accepted in either order
            s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == `CTU_ADDR_CONTROL || aw_addr_reg == `CTU_ADDR_CURRENT) ?
                                2'h0 : 2'h2;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end

            // Read channel: one outstanding read
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                case (s_axi_araddr)
                    `CTU_ADDR_CONTROL: begin
                        s_axi_rdata <= {16'h0000, control_reg};
                        s_axi_rresp <= 2'h0;
                    end
                    `CTU_ADDR_CURRENT: begin
                        s_axi_rdata <= {16'h0000, current_reg};
                        s_axi_rresp <= 2'h0;
                    end
                    `CTU_ADDR_LINK: begin
                        // Delay state and trip level, handy for bring-up
                        s_axi_rdata <= {27'h0, comparator_trip, delay_pulse_out,
                                        charge_delay_capacitor, state_reg};
                        s_axi_rresp <= 2'h0;
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end

            // Analog controls follow the registers; idle stop cuts comparator routing, trigger and source enable, not ground, range or trim
            source_to_comparator_b <= running & delay_gen_enable;
            current_ground         <= control_reg[`CTU_BIT_GROUND];
            trigger_out            <= running & control_reg[`CTU_BIT_TRIGGER];
            current_range          <= current_reg[`CTU_RANGE_HI:`CTU_RANGE_LO];
            current_source_on      <= running &
                                      (current_reg[`CTU_RANGE_HI:`CTU_RANGE_LO] != `CTU_RANGE_OFF);
            current_trim           <= current_reg[`CTU_TRIM_HI:`CTU_TRIM_LO];

            // Delay generation sequence
            case (state_reg)
                ST_IDLE: begin
                    delay_pulse_out <= 1'b0;
                    if (running & delay_gen_enable & (edge1_ev | edge2_ev)) begin
                        state_reg              <= ST_CHARGING;
                        charge_delay_capacitor <= 1'b1;
                    end
                end
                ST_CHARGING: begin
                    if (~running | ~delay_gen_enable) begin
                        state_reg              <= ST_IDLE;
                        charge_delay_capacitor <= 1'b0;
                    end else if (comparator_trip) begin
                        state_reg              <= ST_PULSE;
                        charge_delay_capacitor <= 1'b0;
                        delay_pulse_out        <= 1'b1;
                        pulse_cnt_reg          <= `CTU_PULSE_CYCLES;
                    end
                end
                ST_PULSE: begin
                    if (pulse_cnt_reg <= 4'h1) begin
                        state_reg       <= ST_IDLE;
                        delay_pulse_out <= 1'b0;
                    end else begin
                        pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg              <= ST_IDLE;
                    charge_delay_capacitor <= 1'b0;
                    delay_pulse_out        <= 1'b0;
                end
            endcase
        end
    end

endmodule // charge_time_unit

`default_nettype wire

// File: charge_time_unit_asserts.sv
// Checker: bus handshakes and delay-pulse relations at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module charge_time_unit_asserts (
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        comparator_trip,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        source_to_comparator_b,
    input wire logic        charge_delay_capacitor,
    input wire logic        delay_pulse_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_trip; charge_delay_capacitor && comparator_trip; endsequence
    sequence s_aw_taken; s_axi_awvalid && s_axi_awready; endsequence
    property p_pulse_single; delay_pulse_out |=> !delay_pulse_out; endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("delay pulse too long");
    property p_pulse_after_trip; s_trip |=> delay_pulse_out && !charge_delay_capacitor; endproperty
    a_pulse_after_trip: assert property (p_pulse_after_trip) else $error("no pulse after trip");
    property p_pulse_cause; $rose(delay_pulse_out) |-> $past(comparator_trip) && $past(charge_delay_capacitor); endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without trip");
    property p_charge_routed; $rose(charge_delay_capacitor) |-> source_to_comparator_b; endproperty
    a_charge_routed: assert property (p_charge_routed) else $error("charging while not routed");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response changed");
    property p_write_answer; s_aw_taken |-> ##[1:3] s_axi_bvalid; endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");
    property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
endmodule // charge_time_unit_asserts
`default_nettype wire

// File: charge_time_unit_regs.vh
// Register offsets, field positions, reset values and timing counts of the charge-time unit
`ifndef CHARGE_TIME_UNIT_REGS_VH
`define CHARGE_TIME_UNIT_REGS_VH

`define CTU_ADDR_CONTROL      4'h0
`define CTU_ADDR_CURRENT      4'h4
`define CTU_ADDR_LINK         4'h8

`define CTU_CONTROL_RESET     16'h0000
`define CTU_CURRENT_RESET     16'h0000
`define CTU_CONTROL_WMASK     16'hBFFF
`define CTU_CURRENT_WMASK     16'hFF00

`define CTU_BIT_ENABLE        15
`define CTU_BIT_IDLE_STOP     13
`define CTU_BIT_DELAY_GEN     12
`define CTU_BIT_EDGE_PASS     11
`define CTU_BIT_EDGE_ORDER    10
`define CTU_BIT_GROUND        9
`define CTU_BIT_TRIGGER       8
`define CTU_BIT_POL2          7
`define CTU_SEL2_HI           6
`define CTU_SEL2_LO           5
`define CTU_BIT_POL1          4
`define CTU_SEL1_HI           3
`define CTU_SEL1_LO           2
`define CTU_BIT_SEEN2         1
`define CTU_BIT_SEEN1         0

`define CTU_TRIM_HI           15
`define CTU_TRIM_LO           10
`define CTU_RANGE_HI          9
`define CTU_RANGE_LO          8

`define CTU_SRC_PIN_ONE       2'h3
`define CTU_SRC_PIN_TWO       2'h2
`define CTU_SRC_COMPARE       2'h1
`define CTU_SRC_TIMER         2'h0

`define CTU_RANGE_X100        2'h3
`define CTU_RANGE_X10         2'h2
`define CTU_RANGE_BASE        2'h1
`define CTU_RANGE_OFF         2'h0

`define CTU_PULSE_CYCLES      4'h1

`endif

// File: edge_comparator_model.sv
// Far-side model: edge sources and the delay comparator on a ramping capacitor
`timescale 1ns/1ps
`default_nettype none
module edge_comparator_model #(parameter int TRIP_CYCLES = 5) (
    input  wire logic       clock,
    input  wire logic [3:0] src_level,
    input  wire logic       charge_delay_capacitor,
    output logic            edge_pin_one,
    output logic            edge_pin_two,
    output logic            output_compare_source,
    output logic            timer_source,
    output logic            comparator_trip
);
    int ramp = 0;
    assign {edge_pin_one, edge_pin_two, output_compare_source, timer_source} = src_level;
    // Trips only after a real charge time, so an early pulse shows up
    assign comparator_trip = (ramp >= TRIP_CYCLES);
    // Capacitor discharges at once when charging stops
    always @(posedge clock) ramp <= charge_delay_capacitor ? ramp + 1 : 0;
endmodule // edge_comparator_model
`default_nettype wire
